// *** logic/dub_top.sv ***
// How it works
// RQ1 - Program store is 1024 sixteen-bit words
// RQ2 - Unit zero starts 0x000, unit one 0x001
// RQ3 - Interrupts send only unit zero to 0x010
// RQ4 - Words 0x3F8 to 0x3FF reserved for system
// RQ5 - Word 0x001 is unit-one start or user code
// RQ6 - Either unit may run code anywhere
// RQ7 - Wait 1024 low RC cycles after power-on
// RQ8 - Unit one disabled after reset
// RQ9 - Single-cycle byte or bit SRAM access
// RQ10 - Each unit stacks in SRAM via own pointer
// RQ11 - Any SRAM byte is an 8-bit pointer
// RQ12 - One shared ALU, accumulator or SRAM operands
// RQ13 - Three oscillator enables at bits 7, 4, 2
// RQ14 - Boot: crystal off, both RC oscillators on
// RQ15 - Clock-mode register selects system clock source
// RQ16 - Units run on alternate clock cycles
// RQ17 - Single-unit mode keeps unit one off
// RQ18 - Ten-bit counters step each own instruction
// RQ19 - Wait counted on low RC ticks, releases unit zero
`timescale 1ns/1ps
`default_nettype none
module dub_top (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic single_unit_i,
    input wire logic low_rc_tick_i,
    input wire logic irq_i,
    input wire logic [15:0] prog_data_i,
    input wire logic branch_i,
    input wire logic [9:0] branch_addr_i,
    input wire logic call_i,
    input wire logic ret_i,
    input wire logic sp_load_i,
    input wire logic [2:0] alu_op_i,
    input wire logic alu_src_sram_i,
    input wire logic alu_dst_sram_i,
    input wire logic [7:0] imm_i,
    input wire logic [7:0] mem_addr_i,
    input wire logic mem_indirect_i,
    input wire logic mem_bit_i,
    input wire logic [2:0] mem_bit_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [9:0] prog_addr_o,
    output logic exec_o,
    output logic exec_unit_o,
    output logic sys_area_fetch_o,
    output logic [7:0] acc0_o,
    output logic [7:0] acc1_o,
    output logic xtal_en_o,
    output logic high_rc_en_o,
    output logic low_rc_en_o,
    output logic [1:0] clk_src_o
);
    ////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_q;
    logic rst_n;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    ////////////////////////////////////////////////////////////////////
    // Boot wait and task switch
    typedef enum logic {DUB_BOOT_WAIT, DUB_RUN} dub_boot_t;
    dub_boot_t boot_st, next_boot_st;
    logic [10:0] wait_cnt, next_wait_cnt;
    logic slot, next_slot;
    logic single_q, next_single_q;
    logic [1:0] unit_en, next_unit_en;
    logic [7:0] clk_mode, next_clk_mode;
    logic [7:0] xtal_ctrl, next_xtal_ctrl;
    logic run_en;

    always_comb begin
        next_boot_st = boot_st;
        next_wait_cnt = wait_cnt;
        next_slot = slot;
        next_single_q = single_q;
        case (boot_st)
            DUB_BOOT_WAIT: begin
                // Counts only low RC ticks, so it tracks that oscillator
                if (low_rc_tick_i) begin
                    next_wait_cnt = wait_cnt + 11'h001; // RQ19
                end
                if (low_rc_tick_i && wait_cnt == dub_pkg::BOOT_WAIT_CYCLES - 11'h001) begin
                    next_boot_st = DUB_RUN; // RQ7 RQ19
                    next_single_q = single_unit_i;
                    next_slot = 1'b0;
                end
            end
            DUB_RUN: begin
                next_slot = ~slot; // RQ16
            end
            default: begin
                next_boot_st = DUB_BOOT_WAIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            boot_st <= DUB_BOOT_WAIT;
            wait_cnt <= 11'h000;
            slot <= 1'b0;
            single_q <= 1'b0;
        end else if (ce_i) begin
            boot_st <= next_boot_st;
            wait_cnt <= next_wait_cnt;
            slot <= next_slot;
            single_q <= next_single_q;
        end
    end

    // Unit one's slot stays idle when it is off, so unit zero keeps half rate
    assign run_en = (boot_st == DUB_RUN) && unit_en[slot] &&
        !(slot && single_q); // RQ16 RQ17

    ////////////////////////////////////////////////////////////////////
    // Processing unit state and shared SRAM
    logic [9:0] pc [2];
    logic [9:0] next_pc [2];
    logic [7:0] sp [2];
    logic [7:0] next_sp [2];
    logic [7:0] acc [2];
    logic [7:0] next_acc [2];
    logic [7:0] mem [dub_pkg::SRAM_BYTES];
    logic [7:0] next_mem [dub_pkg::SRAM_BYTES];
    logic irq_pend, next_irq_pend;
    logic take_irq;
    logic [7:0] eff_addr;
    logic [7:0] opnd;
    logic [7:0] rdat;
    logic [7:0] alu_res;
    logic [9:0] ret_pc;
    logic [7:0] sp_pop;

    assign take_irq = run_en && !slot && irq_pend; // RQ3
    always_comb begin
        // Unmapped pointer targets above 63 read zero, writes dropped
        eff_addr = mem_indirect_i ? mem[mem_addr_i[5:0]] : mem_addr_i; // RQ11
        rdat = (eff_addr < 8'h40) ? mem[eff_addr[5:0]] : 8'h00; // RQ9
        opnd = alu_src_sram_i ? rdat : imm_i; // RQ12
        case (alu_op_i)
            3'h0: alu_res = opnd;
            3'h1: alu_res = acc[slot] + opnd;
            3'h2: alu_res = acc[slot] - opnd;
            3'h3: alu_res = acc[slot] & opnd;
            3'h4: alu_res = acc[slot] | opnd;
            3'h5: alu_res = acc[slot] ^ opnd;
            3'h6: alu_res = {opnd[6:0], 1'b0};
            default: alu_res = {1'b0, opnd[7:1]};
        endcase
        if (mem_bit_i) begin
            alu_res = rdat;
            alu_res[mem_bit_sel_i] = imm_i[0]; // RQ9
        end
    end

    always_comb begin
        next_pc = pc;
        next_sp = sp;
        next_acc = acc;
        next_mem = mem;
        next_irq_pend = (irq_pend & ~take_irq) | irq_i;
        sp_pop = sp[slot] - 8'h02;
        ret_pc = {mem[sp_pop[5:0] + 6'h01][1:0], mem[sp_pop[5:0]]};
        if (run_en) begin
            if (alu_dst_sram_i || mem_bit_i) begin
                if (eff_addr < 8'h40) begin
                    next_mem[eff_addr[5:0]] = alu_res; // RQ12
                end
            end else begin
                next_acc[slot] = alu_res; // RQ12
            end
            if (sp_load_i) begin
                next_sp[slot] = imm_i; // RQ10
            end
            if (take_irq || call_i) begin
                // Return address is pushed low byte first on own stack
                next_mem[sp[slot][5:0]] = take_irq ? pc[0][7:0] : 8'(pc[slot] + 10'h001);
                next_mem[sp[slot][5:0] + 6'h01] = take_irq ? {6'h00, pc[0][9:8]} :
                    {6'h00, 2'(10'(pc[slot] + 10'h001) >> 8)}; // RQ10
                next_sp[slot] = sp[slot] + 8'h02;
            end
            if (take_irq) begin
                next_pc[0] = dub_pkg::IRQ_VECTOR; // RQ3
            end else if (call_i || branch_i) begin
                next_pc[slot] = branch_addr_i; // RQ6 RQ18
            end else if (ret_i) begin
                next_pc[slot] = ret_pc;
                next_sp[slot] = sp_pop; // RQ10
            end else begin
                next_pc[slot] = pc[slot] + 10'h001; // RQ18 RQ5
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pc[0] <= dub_pkg::PC0_RESET; // RQ2
            pc[1] <= dub_pkg::PC1_RESET; // RQ2
            sp[0] <= 8'h00;
            sp[1] <= 8'h00;
            acc[0] <= 8'h00;
            acc[1] <= 8'h00;
            irq_pend <= 1'b0;
            for (int i = 0; i < dub_pkg::SRAM_BYTES; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (ce_i) begin
            pc <= next_pc;
            sp <= next_sp;
            acc <= next_acc;
            irq_pend <= next_irq_pend;
            mem <= next_mem;
        end
    end

    // One shared program port: whichever unit owns the slot fetches
    assign prog_addr_o = pc[slot]; // RQ1 RQ6
    assign exec_o = run_en;
    assign exec_unit_o = slot;
    assign sys_area_fetch_o = run_en && (pc[slot] >= dub_pkg::SYS_AREA_BASE); // RQ4
    assign acc0_o = acc[0];
    assign acc1_o = acc[1];

    ////////////////////////////////////////////////////////////////////
    // Wishbone registers
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic wr_hit;

    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !ack && wb_sel_i[0];
    always_comb begin
        next_ack = wb_cyc_i && wb_stb_i && !ack;
        next_rdata = 32'h0000_0000;
        next_unit_en = unit_en;
        next_clk_mode = clk_mode;
        next_xtal_ctrl = xtal_ctrl;
        if (wr_hit) begin
            case (wb_adr_i)
                dub_pkg::UNIT_EN_OFS: next_unit_en = wb_dat_i[1:0];
                dub_pkg::CLK_MODE_OFS: next_clk_mode = wb_dat_i[7:0]; // RQ15
                dub_pkg::XTAL_CTRL_OFS: next_xtal_ctrl = wb_dat_i[7:0];
                default: next_unit_en = unit_en;
            endcase
        end
        if (single_q) begin
            next_unit_en[dub_pkg::UNIT1_EN_BIT] = 1'b0; // RQ17
        end
        case (wb_adr_i)
            dub_pkg::UNIT_EN_OFS: next_rdata[1:0] = unit_en;
            dub_pkg::CLK_MODE_OFS: next_rdata[7:0] = clk_mode;
            dub_pkg::XTAL_CTRL_OFS: next_rdata[7:0] = xtal_ctrl;
            dub_pkg::STATUS_OFS: begin
                next_rdata[dub_pkg::STAT_BOOT_BIT] = (boot_st == DUB_RUN);
                next_rdata[dub_pkg::STAT_SINGLE_BIT] = single_q;
                next_rdata[dub_pkg::STAT_SLOT_BIT] = slot;
                next_rdata[dub_pkg::STAT_PC0_LSB +: 10] = pc[0];
                next_rdata[dub_pkg::STAT_PC1_LSB +: 10] = pc[1];
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
            unit_en <= dub_pkg::UNIT_EN_RESET; // RQ8
            clk_mode <= dub_pkg::CLK_MODE_RESET; // RQ14
            xtal_ctrl <= dub_pkg::XTAL_CTRL_RESET; // RQ14
        end else if (ce_i) begin
            ack <= next_ack;
            rdata <= next_rdata;
            unit_en <= next_unit_en;
            clk_mode <= next_clk_mode;
            xtal_ctrl <= next_xtal_ctrl;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign xtal_en_o = xtal_ctrl[dub_pkg::XTAL_EN_BIT]; // RQ13
    assign high_rc_en_o = clk_mode[dub_pkg::HIGH_RC_EN_BIT]; // RQ13
    assign low_rc_en_o = clk_mode[dub_pkg::LOW_RC_EN_BIT]; // RQ13
    assign clk_src_o = clk_mode[dub_pkg::CLK_SRC_LSB +: 2]; // RQ15
endmodule
`default_nettype wire

// *** logic/dub_pkg.sv ***
`default_nettype none
package dub_pkg;
    // Memory sizes
    localparam int PC_W = 10;
    localparam int PROG_WORDS = 1024;
    localparam int PROG_DATA_W = 16;
    localparam int SRAM_BYTES = 64;
    localparam int SRAM_AW = 6;
    localparam int NUM_UNITS = 2;
    // Program map
    localparam logic [9:0] PC0_RESET = 10'h000;
    localparam logic [9:0] PC1_RESET = 10'h001;
    localparam logic [9:0] IRQ_VECTOR = 10'h010;
    localparam logic [9:0] SYS_AREA_BASE = 10'h3F8;
    localparam logic [9:0] SYS_AREA_LAST = 10'h3FF;
    // Power-on wait in low RC cycles
    localparam logic [10:0] BOOT_WAIT_CYCLES = 11'h0400;
    // Register byte offsets
    localparam logic [7:0] UNIT_EN_OFS = 8'h00;
    localparam logic [7:0] CLK_MODE_OFS = 8'h04;
    localparam logic [7:0] XTAL_CTRL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    // Field positions
    localparam int UNIT0_EN_BIT = 0;
    localparam int UNIT1_EN_BIT = 1;
    localparam int XTAL_EN_BIT = 7;
    localparam int HIGH_RC_EN_BIT = 4;
    localparam int LOW_RC_EN_BIT = 2;
    localparam int CLK_SRC_LSB = 0;
    localparam int STAT_BOOT_BIT = 0;
    localparam int STAT_SINGLE_BIT = 1;
    localparam int STAT_SLOT_BIT = 2;
    localparam int STAT_PC0_LSB = 8;
    localparam int STAT_PC1_LSB = 18;
    // Reset values
    localparam logic [1:0] UNIT_EN_RESET = 2'h1;
    localparam logic [7:0] CLK_MODE_RESET = 8'h14;
    localparam logic [7:0] XTAL_CTRL_RESET = 8'h00;
    // Clock source codes
    localparam logic [1:0] SRC_HIGH_RC = 2'h0;
    localparam logic [1:0] SRC_LOW_RC = 2'h1;
    localparam logic [1:0] SRC_XTAL = 2'h2;
    // ALU operations
    typedef enum logic [2:0] {
        DUB_OP_PASS, DUB_OP_ADD, DUB_OP_SUB, DUB_OP_AND,
        DUB_OP_OR, DUB_OP_XOR, DUB_OP_SHL, DUB_OP_SHR
    } dub_alu_op_t;
endpackage
`default_nettype wire

// *** dv/dub_prog_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module dub_prog_store (
    input wire logic [9:0] addr_i,
    output logic [15:0] word_o
);
    // Word carries its own address, so a wrong fetch address is visible
    assign word_o = {6'h2a, addr_i};
endmodule
`default_nettype wire

// *** dv/dub_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module dub_top_checker (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic single_unit_i,
    input wire logic low_rc_tick_i,
    input wire logic irq_i,
    input wire logic branch_i,
    input wire logic [9:0] branch_addr_i,
    input wire logic call_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [9:0] prog_addr_o,
    input wire logic exec_o,
    input wire logic exec_unit_o,
    input wire logic sys_area_fetch_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic [10:0] ticks;
    logic [10:0] next_ticks;
    logic u1_on;
    logic next_u1_on;
    logic take;
    assign take = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
    // Saturates at 1024 so the boot window never reopens
    always_comb begin
        next_ticks = ticks + {10'h000, low_rc_tick_i && ce_i && !ticks[10]};
        next_u1_on = u1_on || (take && wb_we_i && wb_sel_i[0]
            && wb_adr_i == dub_pkg::UNIT_EN_OFS && wb_dat_i[1]);
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ticks <= 11'h000;
            u1_on <= 1'b0;
        end else begin
            ticks <= next_ticks;
            u1_on <= next_u1_on;
        end
    end
    ////////////////////////////////////////////////////////////////
    ack_follows_req_a: assert property (take |=> wb_ack_o)
        else $error("ack missing");
    ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    slot_alternates_a: assert property (ce_i && exec_o |=>
        exec_unit_o != $past(exec_unit_o)) else $error("slot stuck");
    sys_area_flag_a: assert property (sys_area_fetch_o ==
        (exec_o && prog_addr_o >= dub_pkg::SYS_AREA_BASE)) else $error("sys flag");
    boot_hold_a: assert property (!ticks[10] |-> !exec_o)
        else $error("early run");
    unit_one_gate_a: assert property (exec_o && exec_unit_o |->
        u1_on && !single_unit_i) else $error("unit one ran");
    branch_load_a: assert property (ce_i && exec_o && !exec_unit_o && branch_i
        && !call_i && !irq_i && !$past(irq_i, 1) && !$past(irq_i, 2)
        |-> ##2 (!exec_o || prog_addr_o == $past(branch_addr_i, 2)))
        else $error("branch lost");
    irq_vector_a: assert property (ce_i && exec_o && exec_unit_o && irq_i
        |-> ##3 (prog_addr_o == dub_pkg::IRQ_VECTOR)) else $error("no vector");
    cover property (exec_o && exec_unit_o);
    cover property (sys_area_fetch_o);
    cover property (take && wb_we_i);
endmodule
bind dub_top dub_top_checker u_chk (.*);
`default_nettype wire

// *** dv/dual_unit_boot_and_memory_map_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_unit_boot_and_memory_map_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic single = 1'b1;
    logic tick = 1'b0;
    logic irq = 1'b0;
    // Top six bits: return, stack load, bit write, bit index
    logic [39:0] ins = '0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, q;
    logic ack, ex, exu, sysf, xe, he, le;
    logic [9:0] paddr;
    logic [15:0] pword;
    logic [7:0] acc0;
    logic [1:0] csrc;
    int error_cnt = 0;
    int compares = 0;
    always #5 clk = ~clk;
    dub_prog_store store (.addr_i(paddr), .word_o(pword));
    dub_top dut (.ref_clk_i(clk), .resetn_i(rstn), .ce_i(1'b1), .single_unit_i(single),
        .low_rc_tick_i(tick), .irq_i(irq), .prog_data_i(pword), .alu_op_i(ins[33:31]),
        .alu_src_sram_i(ins[30]), .alu_dst_sram_i(ins[29]), .imm_i(ins[28:21]),
        .mem_addr_i(ins[20:13]), .mem_indirect_i(ins[12]), .branch_i(ins[11]),
        .call_i(ins[10]), .branch_addr_i(ins[9:0]), .ret_i(ins[39]), .sp_load_i(ins[38]),
        .mem_bit_i(ins[37]), .mem_bit_sel_i(ins[36:34]), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .prog_addr_o(paddr), .exec_o(ex), .exec_unit_o(exu),
        .sys_area_fetch_o(sysf), .acc0_o(acc0), .acc1_o(), .xtal_en_o(xe),
        .high_rc_en_o(he), .low_rc_en_o(le), .clk_src_o(csrc));
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 60) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    // Request stands until ack is sampled high at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, we, adr, wdat, sel} <= {1'b1, w, a, d, s};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 60);
        tmo(n);
        q = rdat;
        cyc <= 1'b0;
    endtask
    // Instruction lines are live for one slot only, else both units see them
    task automatic issue(input logic u, input logic [39:0] i);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (exu !== ~u && n < 60);
        tmo(n);
        ins <= i;
        @(posedge clk);
        ins <= '0;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_boot(input logic s);
        @(posedge clk);
        {rstn, single} <= {1'b0, s};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        wb(1'b0, dub_pkg::UNIT_EN_OFS, 32'h0, 4'hf);
        chk(q, 32'h0000_0001);
        wb(1'b0, dub_pkg::CLK_MODE_OFS, 32'h0, 4'hf);
        chk(q, 32'h0000_0014);
        wb(1'b0, dub_pkg::XTAL_CTRL_OFS, 32'h0, 4'hf);
        chk(q, 32'h0000_0000);
        chk({27'h0, xe, he, le, csrc}, 32'h0000_000c);
        tick <= 1'b1;
        repeat (1023) @(posedge clk);
        @(negedge clk);
        chk({31'h0, ex}, 32'h0);
        @(posedge clk);
        tick <= 1'b0;
        @(negedge clk);
        chk({20'h0, ex, exu, paddr}, {20'h0, 2'b10, 10'h000});
    endtask
    task automatic t_single();
        repeat (2) @(negedge clk);
        chk({20'h0, ex, exu, paddr}, {20'h0, 2'b10, 10'h001});
        wb(1'b1, dub_pkg::UNIT_EN_OFS, 32'h0000_0003, 4'hf);
        wb(1'b0, dub_pkg::UNIT_EN_OFS, 32'h0, 4'hf);
        chk(q, 32'h0000_0001);
        wb(1'b0, dub_pkg::STATUS_OFS, 32'h0, 4'hf);
        chk(q & 32'h0000_0003, 32'h0000_0003);
    endtask
    task automatic t_dual();
        int n;
        wb(1'b1, dub_pkg::UNIT_EN_OFS, 32'h0000_0003, 4'hf);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(ex === 1'b1 && exu === 1'b1) && n < 60);
        tmo(n);
        chk({22'h0, paddr}, 32'h0000_0001);
        repeat (2) @(negedge clk);
        chk({20'h0, ex, exu, paddr}, {20'h0, 2'b11, 10'h002});
    endtask
    task automatic t_sram();
        issue(1'b0, {6'h00, 3'h0, 2'b01, 8'h3c, 8'h05, 3'b000, 10'h000});
        issue(1'b0, {6'h00, 3'h0, 2'b01, 8'h77, 8'h05, 3'b100, 10'h000});
        issue(1'b0, {6'h00, 3'h0, 2'b10, 8'h00, 8'h3c, 3'b000, 10'h000});
        @(negedge clk);
        chk({24'h0, acc0}, 32'h0000_0077);
        issue(1'b0, {6'h00, 3'h1, 2'b00, 8'h01, 8'h3c, 3'b000, 10'h000});
        @(negedge clk);
        chk({24'h0, acc0}, 32'h0000_0078);
    endtask
    task automatic t_far();
        issue(1'b1, {6'h00, 3'h0, 2'b00, 8'h00, 8'h00, 3'b001, 10'h3f9});
        repeat (2) @(negedge clk);
        chk({21'h0, sysf, paddr}, {21'h0, 1'b1, 10'h3f9});
        issue(1'b0, {6'h00, 3'h0, 2'b00, 8'h00, 8'h00, 3'b010, 10'h005});
        repeat (2) @(negedge clk);
        chk({21'h0, sysf, paddr}, {21'h0, 1'b0, 10'h005});
    endtask
    task automatic t_irq();
        issue(1'b0, '0);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        repeat (2) @(negedge clk);
        chk({31'h0, paddr === dub_pkg::IRQ_VECTOR}, 32'h0);
        @(negedge clk);
        chk({22'h0, paddr}, {22'h0, dub_pkg::IRQ_VECTOR});
    endtask
    // Own stack at 0x10: call pushes 0x041, bit 3 set in 0x77, return pops
    task automatic t_stack();
        issue(1'b0, {6'h10, 3'h0, 2'b00, 8'h10, 8'h00, 3'b010, 10'h040});
        issue(1'b0, {6'h00, 3'h0, 2'b00, 8'h00, 8'h00, 3'b001, 10'h123});
        issue(1'b0, {6'h00, 3'h0, 2'b10, 8'h00, 8'h10, 3'b000, 10'h000});
        @(negedge clk);
        chk({24'h0, acc0}, 32'h0000_0041);
        issue(1'b0, {6'h0b, 3'h0, 2'b00, 8'h01, 8'h3c, 3'b000, 10'h000});
        issue(1'b0, {6'h00, 3'h0, 2'b10, 8'h00, 8'h3c, 3'b000, 10'h000});
        @(negedge clk);
        chk({24'h0, acc0}, 32'h0000_007f);
        issue(1'b0, {6'h20, 3'h0, 2'b00, 8'h00, 8'h00, 3'b000, 10'h000});
        repeat (2) @(negedge clk);
        chk({22'h0, paddr}, 32'h0000_0041);
    endtask
    task automatic t_osc();
        wb(1'b1, dub_pkg::XTAL_CTRL_OFS, 32'h0000_0080, 4'hf);
        wb(1'b1, dub_pkg::CLK_MODE_OFS, 32'h0000_0002, 4'hf);
        wb(1'b1, dub_pkg::XTAL_CTRL_OFS, 32'h0000_0000, 4'he);
        wb(1'b0, 8'h20, 32'h0, 4'hf);
        chk(q, 32'h0000_0000);
        @(negedge clk);
        chk({27'h0, xe, he, le, csrc}, 32'h0000_0012);
    endtask
    initial begin
        t_boot(1'b1);
        t_single();
        t_boot(1'b0);
        t_dual();
        t_sram();
        t_far();
        t_irq();
        t_stack();
        t_osc();
        report_and_stop();
    end
endmodule
`default_nettype wire
